/* File: inc/ici_consts.vh */
// Constants for the interrupt CPU interface register block.
// Included by the register block and by its sim checker and bench; definitions only.
`ifndef ICI_CONSTS_VH
`define ICI_CONSTS_VH

// System-register selectors (op0,op1,crn,crm,op2 packed into 14 bits)
`define ICI_SEL_AP0       14'h3C84
`define ICI_SEL_AP1       14'h3C90
`define ICI_SEL_BPR0      14'h3C83
`define ICI_SEL_BPR1      14'h3CC3
`define ICI_SEL_CTLR      14'h3CC4
`define ICI_SEL_EOIR0     14'h3C81
`define ICI_SEL_EOIR1     14'h3CC1
`define ICI_SEL_DIR       14'h3CB1

// Control register fields
`define ICI_CTL_COMMON_BINARY_POINT      0
`define ICI_CTL_END_OF_INTERRUPT_MODE   1
`define ICI_CTL_MASK_HINT_ENABLE      6
`define ICI_CTL_PRI_LSB   8
`define ICI_CTL_ID_LSB    11
`define ICI_CTL_SYS_ERROR_IRQ_SUPPORT      14
`define ICI_CTL_A3V       15

// Read-only feature values
`define ICI_PRIORITY_WIDTH_VAL   3'h4
`define ICI_IDENTIFIER_WIDTH_VAL    3'h0
`define ICI_A3V_VAL       1'h1
`define ICI_SYS_ERROR_IRQ_SUPPORT_VAL      1'h0

// Binary-point minimums and reset values
`define ICI_BPR0_MIN      3'h2
`define ICI_BPR1_S_MIN    3'h2
`define ICI_BPR1_NS_MIN   3'h3
`define ICI_BPR0_RST      3'h2
`define ICI_BPR1_S_RST    3'h2
`define ICI_BPR1_NS_RST   3'h3
`define ICI_AP_RST        32'h00000000

`endif

/* File: hw/ici_bp_clamp.v */
// Binary-point field clamp: raises a written value to the implemented minimum.
// Pure combinational; used by the register block for each binary-point copy.
`timescale 1ns/1ps
`default_nettype none

module ici_bp_clamp (
	input  wire [2:0] val_in,
	input  wire [2:0] min_in,
	output wire [2:0] val_out
);

	assign val_out = (val_in < min_in) ? min_in : val_in;

endmodule // ici_bp_clamp

`default_nettype wire

/* File: hw/ici_regs.v */
// Interrupt CPU interface system-register block of a core.
// Assumes a core-side system-register access port; distributor is elsewhere.
`timescale 1ns/1ps
`default_nettype none
`include "ici_consts.vh"

module ici_regs #(
	parameter PRIO_BITS = 5
) (
	input  wire        clk_in,
	input  wire        rst_n_in,
	input  wire        ce_in,
	input  wire        sr_valid_in,
	input  wire        sr_write_in,
	input  wire [13:0] sr_sel_in,
	input  wire [31:0] sr_wdata_in,
	input  wire        secure_in,
	input  wire        el1_ns_in,
	input  wire        hyp_virt_route_in,
	input  wire        el3_mask_hint_in,
	input  wire [2:0]  el3_id_width_in,
	input  wire [7:0]  ack_prio_in,
	input  wire        ack_grp1_in,
	input  wire        ack_valid_in,
	output reg  [31:0] sr_rdata_out,
	output reg         sr_err_out,
	output wire        virt_access_out,
	output reg         prio_drop_out,
	output reg         deactivate_out,
	output reg  [23:0] deact_intid_out,
	output wire [2:0]  preempt_bp0_out,
	output wire [2:0]  preempt_bp1_out
);

	localparam LEVELS = 1 << PRIO_BITS;

	reg  [LEVELS-1:0] ap0_ff;
	reg  [LEVELS-1:0] ap1_ff;
	reg  [2:0]        bpr0_ff;
	reg  [2:0]        bpr1_s_ff;
	reg  [2:0]        bpr1_ns_ff;
	reg               end_of_interrupt_mode_ff;
	reg               common_binary_point_ff;
	wire [2:0]        bp0_clamped;
	wire [2:0]        bp1s_clamped;
	wire [2:0]        bp1ns_clamped;
	wire              phys_acc;
	wire              wr;
	wire [31:0]       ctl_rd;
	wire [4:0]        ack_lvl;
	wire [LEVELS-1:0] ap0_low;
	wire [LEVELS-1:0] ap1_low;
	reg  [LEVELS-1:0] nxt_ap0;
	reg  [LEVELS-1:0] nxt_ap1;
	wire [2:0]        bpr1_cur;

	assign virt_access_out = hyp_virt_route_in & el1_ns_in & ~secure_in;
	assign phys_acc = sr_valid_in & ~virt_access_out;
	assign wr       = phys_acc & sr_write_in & ce_in;

	ici_bp_clamp u_bp0 (
		.val_in  (sr_wdata_in[2:0]),
		.min_in  (`ICI_BPR0_MIN),
		.val_out (bp0_clamped)
	);
	ici_bp_clamp u_bp1s (
		.val_in  (sr_wdata_in[2:0]),
		.min_in  (`ICI_BPR1_S_MIN),
		.val_out (bp1s_clamped)
	);
	ici_bp_clamp u_bp1ns (
		.val_in  (sr_wdata_in[2:0]),
		.min_in  (`ICI_BPR1_NS_MIN),
		.val_out (bp1ns_clamped)
	);

	assign bpr1_cur = secure_in ? bpr1_s_ff : bpr1_ns_ff;
	assign preempt_bp0_out = bpr0_ff;
	assign preempt_bp1_out = common_binary_point_ff ? bpr0_ff : bpr1_cur;

	assign ack_lvl = ack_prio_in[7:3];

	// Lowest set bit marks the running priority to drop
	genvar gi;
	generate
		for (gi = 0; gi < LEVELS; gi = gi + 1) begin : g_low
			if (gi == 0) begin : g_z
				assign ap0_low[gi] = ap0_ff[0];
				assign ap1_low[gi] = ap1_ff[0];
			end else begin : g_n
				assign ap0_low[gi] = ap0_ff[gi] & ~|ap0_ff[gi-1:0];
				assign ap1_low[gi] = ap1_ff[gi] & ~|ap1_ff[gi-1:0];
			end
		end
	endgenerate

	assign ctl_rd = {16'h0000, `ICI_A3V_VAL, `ICI_SYS_ERROR_IRQ_SUPPORT_VAL, el3_id_width_in,
		`ICI_PRIORITY_WIDTH_VAL, 1'b0, el3_mask_hint_in, 4'h0, end_of_interrupt_mode_ff, common_binary_point_ff};

	reg         sel_ap0;
	reg         sel_ap1;
	reg         sel_bpr0;
	reg         sel_bpr1;
	reg         sel_ctlr;
	reg         sel_eoir0;
	reg         sel_eoir1;
	reg         sel_dir;
	reg  [31:0] nxt_rdata;
	reg         nxt_err;
	reg         nxt_deact;

	// Selector decode; one register at most per access
	always @* begin
		sel_ap0   = 1'b0;
		sel_ap1   = 1'b0;
		sel_bpr0  = 1'b0;
		sel_bpr1  = 1'b0;
		sel_ctlr  = 1'b0;
		sel_eoir0 = 1'b0;
		sel_eoir1 = 1'b0;
		sel_dir   = 1'b0;
		if (sr_sel_in == `ICI_SEL_AP0) begin
			sel_ap0 = 1'b1;
		end else if (sr_sel_in == `ICI_SEL_AP1) begin
			sel_ap1 = 1'b1;
		end else if (sr_sel_in == `ICI_SEL_BPR0) begin
			sel_bpr0 = 1'b1;
		end else if (sr_sel_in == `ICI_SEL_BPR1) begin
			sel_bpr1 = 1'b1;
		end else if (sr_sel_in == `ICI_SEL_CTLR) begin
			sel_ctlr = 1'b1;
		end else if (sr_sel_in == `ICI_SEL_EOIR0) begin
			sel_eoir0 = 1'b1;
		end else if (sr_sel_in == `ICI_SEL_EOIR1) begin
			sel_eoir1 = 1'b1;
		end else if (sr_sel_in == `ICI_SEL_DIR) begin
			sel_dir = 1'b1;
		end
	end

	// Qualified strobes; ce_in low or a virtual route blocks them
	wire rd      = phys_acc & ~sr_write_in & ce_in;
	wire eoi0    = wr & sel_eoir0;
	wire eoi1    = wr & sel_eoir1;
	wire dirw    = wr & sel_dir;
	wire eoi_any = eoi0 | eoi1;

	always @* begin
		nxt_ap0 = ap0_ff;
		nxt_ap1 = ap1_ff;
		// End-of-interrupt clears the running priority
		if (eoi0) begin
			nxt_ap0 = nxt_ap0 & ~ap0_low;
		end
		if (eoi1) begin
			nxt_ap1 = nxt_ap1 & ~ap1_low;
		end
		// Direct bitmap writes restore a saved context
		if (wr && sel_ap0) begin
			nxt_ap0 = sr_wdata_in[LEVELS-1:0];
		end
		if (wr && sel_ap1) begin
			nxt_ap1 = sr_wdata_in[LEVELS-1:0];
		end
		// Acknowledge last so that a same-cycle set wins
		if (ack_valid_in && !ack_grp1_in) begin
			nxt_ap0[ack_lvl] = 1'b1;
		end
		if (ack_valid_in && ack_grp1_in) begin
			nxt_ap1[ack_lvl] = 1'b1;
		end
	end

	// Read data mux; unmapped selectors read zero and flag an error
	always @* begin
		nxt_rdata = 32'h00000000;
		nxt_err   = 1'b0;
		if (sel_ap0) begin
			nxt_rdata[LEVELS-1:0] = ap0_ff;
		end else if (sel_ap1) begin
			nxt_rdata[LEVELS-1:0] = ap1_ff;
		end else if (sel_bpr0) begin
			nxt_rdata[2:0] = bpr0_ff;
		end else if (sel_bpr1) begin
			// Effective value: follows group 0 when the split is common
			nxt_rdata[2:0] = preempt_bp1_out;
		end else if (sel_ctlr) begin
			nxt_rdata = ctl_rd;
		end else begin
			nxt_err = 1'b1;
		end
	end

	always @* begin
		if (end_of_interrupt_mode_ff) begin
			nxt_deact = dirw;
		end else begin
			nxt_deact = eoi_any;
		end
	end

	// Active-priority bitmaps
	always @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			ap0_ff <= {LEVELS{1'b0}};
			ap1_ff <= {LEVELS{1'b0}};
		end else if (ce_in) begin
			ap0_ff <= nxt_ap0;
			ap1_ff <= nxt_ap1;
		end
	end

	// Binary points; the clamps keep each copy at or above its minimum
	always @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			bpr0_ff    <= `ICI_BPR0_RST;
			bpr1_s_ff  <= `ICI_BPR1_S_RST;
			bpr1_ns_ff <= `ICI_BPR1_NS_RST;
		end else if (ce_in) begin
			if (wr && sel_bpr0) begin
				bpr0_ff <= bp0_clamped;
			end
			// Group 1 write lands in the copy of the current security state
			if (wr && sel_bpr1 && secure_in) begin
				bpr1_s_ff <= bp1s_clamped;
			end
			if (wr && sel_bpr1 && !secure_in) begin
				bpr1_ns_ff <= bp1ns_clamped;
			end
		end
	end

	// Control register: only the two writable bits are stored
	always @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			end_of_interrupt_mode_ff <= 1'b0;
			common_binary_point_ff    <= 1'b0;
		end else if (ce_in) begin
			if (wr && sel_ctlr) begin
				end_of_interrupt_mode_ff <= sr_wdata_in[`ICI_CTL_END_OF_INTERRUPT_MODE];
				common_binary_point_ff    <= sr_wdata_in[`ICI_CTL_COMMON_BINARY_POINT];
			end
		end
	end

	// Priority drop and deactivate pulses to the distributor
	always @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			prio_drop_out   <= 1'b0;
			deactivate_out  <= 1'b0;
			deact_intid_out <= 24'h000000;
		end else if (ce_in) begin
			prio_drop_out  <= eoi_any;
			deactivate_out <= nxt_deact;
			// Identifier held until the next end or deactivate write
			if (eoi_any || dirw) begin
				deact_intid_out <= sr_wdata_in[23:0];
			end
		end
	end

	// Read data holds until the next read; the error flag pulses
	always @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			sr_rdata_out <= 32'h00000000;
			sr_err_out   <= 1'b0;
		end else if (ce_in) begin
			sr_err_out <= rd & nxt_err;
			if (rd) begin
				sr_rdata_out <= nxt_rdata;
			end
		end
	end

endmodule // ici_regs

`default_nettype wire

/* File: sim/ici_regs_checker.sv */
// Port assertions for the interrupt CPU interface register block.
// Bound to ici_regs; one clock domain, asynchronous active-low reset.
`timescale 1ns/1ps
`default_nettype none
`include "ici_consts.vh"
module ici_regs_checker (
	input wire        clk_in, rst_n_in, ce_in, sr_valid_in, sr_write_in, secure_in,
	input wire        el1_ns_in, hyp_virt_route_in, el3_mask_hint_in,
	input wire [13:0] sr_sel_in,
	input wire [31:0] sr_wdata_in, sr_rdata_out,
	input wire [2:0]  el3_id_width_in, preempt_bp0_out, preempt_bp1_out,
	input wire        virt_access_out, prio_drop_out, deactivate_out, sr_err_out,
	input wire [23:0] deact_intid_out
);
	default clocking @(posedge clk_in); endclocking
	default disable iff (!rst_n_in);
	wire tk = sr_valid_in & ce_in & ~virt_access_out;
	wire wr = tk & sr_write_in;
	wire rd = tk & ~sr_write_in;
	wire eoi = wr & (sr_sel_in == `ICI_SEL_EOIR0 | sr_sel_in == `ICI_SEL_EOIR1);
	wire dir = wr & sr_sel_in == `ICI_SEL_DIR;
	wire mapped = sr_sel_in == `ICI_SEL_AP0 | sr_sel_in == `ICI_SEL_AP1 |
		sr_sel_in == `ICI_SEL_BPR0 | sr_sel_in == `ICI_SEL_BPR1 | sr_sel_in == `ICI_SEL_CTLR;
	a_eoi_drop: assert property (eoi |=> prio_drop_out)
		else $error("no drop after end write");
	a_drop_cause: assert property (ce_in && !eoi |=> !prio_drop_out)
		else $error("drop without end write");
	a_deact_cause: assert property (ce_in && !(eoi | dir) |=> !deactivate_out)
		else $error("deactivate without cause");
	a_intid_take: assert property (eoi | dir |=>
		deact_intid_out == $past(sr_wdata_in[23:0])) else $error("identifier not taken");
	a_err_unmapped: assert property (rd && !mapped |=>
		sr_err_out && sr_rdata_out == 32'h00000000) else $error("unmapped read not flagged");
	a_err_quiet: assert property (ce_in && !(rd && !mapped) |=> !sr_err_out)
		else $error("error flag without unmapped read");
	a_ctl_fixed: assert property (rd && sr_sel_in == `ICI_SEL_CTLR |=>
		sr_rdata_out[31:14] == 18'h2 && sr_rdata_out[10:7] == 4'h8 && sr_rdata_out[5:2] == 4'h0)
		else $error("control fixed fields wrong");
	a_ctl_mirror: assert property (rd && sr_sel_in == `ICI_SEL_CTLR |=>
		sr_rdata_out[13:11] == $past(el3_id_width_in) && sr_rdata_out[6] == $past(el3_mask_hint_in))
		else $error("control mirror fields wrong");
	a_bp_write: assert property (wr && sr_sel_in == `ICI_SEL_BPR0 |=>
		preempt_bp0_out == ($past(sr_wdata_in[2:0]) < 3'h2 ? 3'h2 : $past(sr_wdata_in[2:0])))
		else $error("group 0 split wrong");
	a_common_binary_point_share: assert property (wr && sr_sel_in == `ICI_SEL_CTLR && sr_wdata_in[0] |=>
		preempt_bp1_out == preempt_bp0_out) else $error("common split not shared");
	a_virt_ns: assert property (virt_access_out |-> el1_ns_in && hyp_virt_route_in && !secure_in)
		else $error("virtual access outside NS EL1");
endmodule // ici_regs_checker
bind ici_regs ici_regs_checker ici_regs_checker_i (.clk_in, .rst_n_in, .ce_in, .sr_valid_in,
	.sr_write_in, .el1_ns_in, .hyp_virt_route_in, .el3_mask_hint_in, .sr_sel_in, .sr_wdata_in,
	.sr_rdata_out, .el3_id_width_in, .preempt_bp0_out, .preempt_bp1_out, .virt_access_out,
	.prio_drop_out, .deactivate_out, .secure_in, .sr_err_out, .deact_intid_out);
`default_nettype wire

/* File: sim/ici_dist_model.sv */
// Distributor stand-in: acknowledges one interrupt per request.
// Answers dly_in+1 cycles after the edge that samples the request; priority lines toggle while idle.
`timescale 1ns/1ps
`default_nettype none
module ici_dist_model (
	input  wire        clk_in, req_in, grp_in,
	input  wire  [7:0] prio_in,
	input  wire  [1:0] dly_in,
	output logic       ack_valid_out, ack_grp1_out,
	output logic [7:0] ack_prio_out
);
	logic [2:0] wait_ff = 3'h0;
	initial {ack_valid_out, ack_grp1_out, ack_prio_out} = 10'h05A;
	always @(posedge clk_in) begin
		ack_valid_out <= 1'b0;
		ack_prio_out <= ~ack_prio_out;
		if (req_in)
			wait_ff <= {1'b1, dly_in};
		else if (wait_ff == 3'h4) begin
			{ack_valid_out, ack_grp1_out, ack_prio_out} <= {1'b1, grp_in, prio_in};
			wait_ff <= 3'h0;
		end else if (wait_ff != 3'h0)
			wait_ff <= wait_ff - 3'h1;
	end
endmodule // ici_dist_model
`default_nettype wire

/* File: sim/ici_regs_bench.sv */
// Self-checking bench for the register block with a distributor model.
// Drives inputs at the falling edge; read data compared one cycle later.
`timescale 1ns/1ps
`default_nettype none
`include "ici_consts.vh"
module ici_regs_bench;
	logic        clk_in = 0, rst_n_in = 0, ce_in = 1, sr_valid_in = 0, sr_write_in = 0;
	logic        secure_in = 0, el1_ns_in = 0, hyp_virt_route_in = 0, el3_mask_hint_in = 1;
	logic        req = 0, gg = 0, pend = 0;
	logic [13:0] sr_sel_in = 0;
	logic [31:0] sr_wdata_in = 0, q[$];
	logic [2:0]  el3_id_width_in = 0, b0;
	logic [7:0]  pp = 0, r = 8'h31;
	logic [1:0]  dly = 0;
	wire         ack_valid_in, ack_grp1_in, virt_access_out;
	wire  [7:0]  ack_prio_in;
	wire  [31:0] sr_rdata_out;
	int          mismatches = 0, samples_checked = 0;
	always #5 clk_in = ~clk_in;
	ici_regs ici_regs_i (.clk_in, .rst_n_in, .ce_in, .sr_valid_in, .sr_write_in, .sr_sel_in,
		.sr_wdata_in, .secure_in, .el1_ns_in, .hyp_virt_route_in, .el3_mask_hint_in,
		.el3_id_width_in, .ack_prio_in, .ack_grp1_in, .ack_valid_in, .sr_rdata_out,
		.sr_err_out(), .virt_access_out, .prio_drop_out(), .deactivate_out(),
		.deact_intid_out(), .preempt_bp0_out(), .preempt_bp1_out());
	ici_dist_model ici_dist_model_i (.clk_in, .req_in(req), .grp_in(gg), .prio_in(pp),
		.dly_in(dly), .ack_valid_out(ack_valid_in), .ack_grp1_out(ack_grp1_in),
		.ack_prio_out(ack_prio_in));
	function automatic logic [7:0] nx(input logic [7:0] v);
		return {v[6:0], v[7] ^ v[5] ^ v[4] ^ v[3]};
	endfunction
	task acc(input logic w, input logic [13:0] s, input logic [31:0] d);
		@(negedge clk_in);
		{sr_valid_in, sr_write_in, sr_sel_in, sr_wdata_in} = {1'b1, w, s, d};
		@(negedge clk_in);
		{sr_valid_in, sr_wdata_in} = {1'b0, ~d};
	endtask
	task rd(input logic [13:0] s, input logic [31:0] e);
		q.push_back(e);
		acc(1'b0, s, 32'h0);
	endtask
	task ack(input logic [7:0] p, input logic g, input logic [1:0] d);
		@(negedge clk_in);
		{req, pp, gg, dly} = {1'b1, p, g, d};
		@(negedge clk_in);
		req = 0;
		repeat (d + 2) @(negedge clk_in);
	endtask
	task cmp(input logic [31:0] e, input logic [31:0] s);
		samples_checked++;
		if (s !== e) begin
			mismatches++;
			$display("BAD sr_rdata_out expected %h seen %h", e, s);
		end
	endtask
	always @(posedge clk_in) pend <= sr_valid_in & ~sr_write_in & ce_in & ~virt_access_out;
	always @(negedge clk_in) if (pend) begin
		cmp(q[0], sr_rdata_out);
		void'(q.pop_front());
	end
	task results;
		$display("compared %0d mismatches %0d", samples_checked, mismatches);
		if (mismatches == 0 && samples_checked > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask
	initial begin
		#60000;
		mismatches++;
		results;
	end
	initial begin
		el3_id_width_in = r[2:0];
		repeat (10) @(negedge clk_in);
		rst_n_in = 1;
		rd(`ICI_SEL_AP0, 32'h0);
		rd(`ICI_SEL_AP1, 32'h0);
		rd(`ICI_SEL_BPR0, 32'h2);
		rd(`ICI_SEL_BPR1, 32'h3);
		rd(`ICI_SEL_CTLR, 32'h8440 | el3_id_width_in << 11);
		rd(14'h0000, 32'h0);
		for (int i = 0; i < 8; i++) begin
			r = nx(r);
			b0 = r[2:0] < 3'h2 ? 3'h2 : r[2:0];
			acc(1'b1, `ICI_SEL_BPR0, {4{r}});
			rd(`ICI_SEL_BPR0, {29'h0, b0});
			acc(1'b1, `ICI_SEL_BPR1, {4{r}} >> 3);
			rd(`ICI_SEL_BPR1, r[5:3] < 3'h3 ? 32'h3 : {29'h0, r[5:3]});
			ack(r, r[0], r[7:6]);
			rd(r[0] ? `ICI_SEL_AP1 : `ICI_SEL_AP0, 32'h1 << r[7:3]);
			acc(1'b1, r[0] ? `ICI_SEL_EOIR1 : `ICI_SEL_EOIR0, {4{r}});
			rd(r[0] ? `ICI_SEL_AP1 : `ICI_SEL_AP0, 32'h0);
		end
		secure_in = 1;
		acc(1'b1, `ICI_SEL_BPR1, 32'h0);
		rd(`ICI_SEL_BPR1, 32'h2);
		secure_in = 0;
		acc(1'b1, `ICI_SEL_CTLR, 32'hFFFFFFFF);
		rd(`ICI_SEL_CTLR, 32'h8443 | el3_id_width_in << 11);
		rd(`ICI_SEL_BPR1, {29'h0, b0});
		ack(8'h10, 1'b1, 2'h3);
		acc(1'b1, `ICI_SEL_EOIR1, 32'h0);
		acc(1'b1, `ICI_SEL_DIR, 32'h00A5C3E1);
		rd(`ICI_SEL_AP1, 32'h0);
		{el1_ns_in, hyp_virt_route_in} = 2'h3;
		acc(1'b1, `ICI_SEL_BPR0, 32'h7);
		{el1_ns_in, hyp_virt_route_in, ce_in} = 3'h0;
		acc(1'b1, `ICI_SEL_BPR0, 32'h7);
		ce_in = 1;
		rd(`ICI_SEL_BPR0, {29'h0, b0});
		repeat (3) @(negedge clk_in);
		results;
	end
endmodule // ici_regs_bench
`default_nettype wire
